// [vbi_acq_pkg.sv]
// package: register map, field layout and framing constants of the line acquisition
package vbi_acq_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hc0;
    localparam logic [7:0] ADDR_MODE = 8'hc1;
    localparam logic [7:0] ADDR_TEST = 8'hc2;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] TEST_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // mode register fields
    localparam int MODE_TTX_BIT = 0;
    localparam int MODE_TOL_BIT = 1;
    localparam int MODE_CRI_LSB = 2;
    localparam int MODE_VPS_BIT = 5;
    // interrupt register fields kept by this block
    localparam int IRQ_L24_FLAG_BIT = 4;
    localparam int IRQ_L24_EN_BIT = 5;

    // ------------------------------------------------------------------
    // line layout
    // ------------------------------------------------------------------
    localparam logic [5:0] TTX_MAX_BYTES = 6'h2a;
    localparam logic [5:0] VPS_MAX_BYTES = 6'h1a;
    localparam logic [4:0] LINE24 = 5'h18;
    localparam logic [4:0] LINE_SAT = 5'h1f;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int LINE_W = 5;
    localparam int IDX_W = 6;
    localparam int BUF_AW = LINE_W + IDX_W;

    // status word fields
    typedef struct packed {
        logic is_ttx;
        logic code_err;
        logic code_ok;
        logic [LINE_W-1:0] line;
    } acq_status_t;

    // one write toward the line buffer
    typedef struct packed {
        logic [BUF_AW-1:0] addr;
        logic [7:0] data;
    } buf_write_t;

    typedef enum logic [3:0] {
        ST_SEARCH = 4'b0001,
        ST_COLLECT = 4'b0010,
        ST_STATUS = 4'b0100,
        ST_WAIT = 4'b1000
    } acq_state_t;

endpackage

// [vbi_line_acquisition.sv]
// module: vbi line acquisition with framing check, line buffer and arbiter
`timescale 1ns/10ps
`default_nettype none
module vbi_line_acquisition
    import vbi_acq_pkg::*;
#(
    parameter logic [7:0] TTX_CODE = 8'h27,
    parameter logic [7:0] VPS_CODE = 8'h99,
    parameter logic [4:0] VBI_FIRST = 5'h06,
    parameter logic [4:0] VBI_LAST = 5'h17,
    parameter logic [4:0] VPS_LINE = 5'h10,
    parameter logic [8:0] H_WIN_BITS = 9'h040
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic slice_bit_i,
    input wire logic slice_strobe_i,
    input wire logic hsync_i,
    input wire logic vsync_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic uc_req_i,
    input wire logic uc_we_i,
    input wire logic [BUF_AW-1:0] uc_addr_i,
    input wire logic [7:0] uc_wdata_i,
    output logic uc_ack_o,
    output logic [7:0] uc_rdata_o,
    output logic line24_done_flag_o,
    output logic [7:0] slicer_test_o,
    output logic [1:0] run_in_compare_select_o
);

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    // number of differing bits between received and expected code
    function automatic logic [3:0] bit_diff(input logic [7:0] a,
                                            input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'b000, a[i] ^ b[i]};
        end
        return n;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic sd_bit;
    logic bit_rise;
    logic hs_rise;
    logic vs_rise;

    // first stage is read only by the second; third stage feeds edges
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
        end else begin
            sync1_reg <= {vsync_i, hsync_i, slice_strobe_i, slice_bit_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign sd_bit = sync2_reg[0];
    assign bit_rise = sync2_reg[1] & ~sync3_reg[1];
    assign hs_rise = sync2_reg[2] & ~sync3_reg[2];
    assign vs_rise = sync2_reg[3] & ~sync3_reg[3];

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] test_reg;
    logic l24_flag_reg;
    logic l24_en_reg;
    logic [7:0] rdata_reg;
    logic wr_irq;

    assign wr_irq = sfr_wr_i && (sfr_addr_i == ADDR_IRQ_STATUS);

    // mode and test registers store whole bytes; software keeps
    // the undefined mode bits and every test bit at zero
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode_reg <= MODE_RESET;
            test_reg <= TEST_RESET;
            l24_en_reg <= 1'b0;
        end else if (sfr_wr_i) begin
            if (sfr_addr_i == ADDR_MODE) begin
                mode_reg <= sfr_wdata_i;
            end
            if (sfr_addr_i == ADDR_TEST) begin
                test_reg <= sfr_wdata_i;
            end
            if (wr_irq) begin
                l24_en_reg <= sfr_wdata_i[IRQ_L24_EN_BIT];
            end
        end
    end

    // register read data, unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_reg <= BYTE_ZERO;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                ADDR_MODE: rdata_reg <= mode_reg;
                ADDR_TEST: rdata_reg <= test_reg;
                ADDR_IRQ_STATUS: begin
                    rdata_reg <= BYTE_ZERO;
                    rdata_reg[IRQ_L24_FLAG_BIT] <= l24_flag_reg;
                    rdata_reg[IRQ_L24_EN_BIT] <= l24_en_reg;
                end
                default: rdata_reg <= BYTE_ZERO;
            endcase
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign slicer_test_o = test_reg;
    assign run_in_compare_select_o = mode_reg[MODE_CRI_LSB +: 2];
    assign line24_done_flag_o = l24_flag_reg;

    // ------------------------------------------------------------------
    // line counting and windows
    // ------------------------------------------------------------------
    logic [LINE_W-1:0] line_reg;
    logic [8:0] hbit_reg;
    logic in_window;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            line_reg <= '0;
        end else if (vs_rise) begin
            line_reg <= '0;
        end else if (hs_rise && line_reg != LINE_SAT) begin
            line_reg <= line_reg + 5'h01;
        end
    end

    // bits seen since the line started; bounds the framing search
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || hs_rise) begin
            hbit_reg <= '0;
        end else if (bit_rise && hbit_reg != 9'h1ff) begin
            hbit_reg <= hbit_reg + 9'h001;
        end
    end

    assign in_window = (line_reg >= VBI_FIRST) && (line_reg <= VBI_LAST)
        && (hbit_reg < H_WIN_BITS);

    // set wins over a software clear written in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            l24_flag_reg <= 1'b0;
        end else if (hs_rise && line_reg == LINE24 - 5'h01) begin
            l24_flag_reg <= 1'b1;
        end else if (wr_irq && !sfr_wdata_i[IRQ_L24_FLAG_BIT]) begin
            l24_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // framing search and byte assembly
    // ------------------------------------------------------------------
    acq_state_t state_reg;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] bitc_reg;
    logic [IDX_W-1:0] idx_reg;
    logic [IDX_W-1:0] max_reg;
    acq_status_t stat_reg;
    logic vps_here;
    logic [3:0] diff_ttx;
    logic [3:0] diff_vps;
    logic tol;
    logic ttx_hit;
    logic vps_hit;
    logic path_busy;
    logic load_byte;
    logic load_stat;

    // bits arrive lsb first
    assign shift_next = {sd_bit, shift_reg[7:1]};
    // vps line replaces teletext on that line only
    assign vps_here = mode_reg[MODE_VPS_BIT] && line_reg == VPS_LINE;
    assign tol = mode_reg[MODE_TOL_BIT];
    assign diff_ttx = bit_diff(shift_next, TTX_CODE);
    assign diff_vps = bit_diff(shift_next, VPS_CODE);
    assign ttx_hit = mode_reg[MODE_TTX_BIT] && !vps_here
        && (diff_ttx == 4'h0 || (tol && diff_ttx == 4'h1));
    assign vps_hit = vps_here
        && (diff_vps == 4'h0 || (tol && diff_vps == 4'h1));

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            shift_reg <= BYTE_ZERO;
        end else if (bit_rise) begin
            shift_reg <= shift_next;
        end
    end

    assign load_byte = state_reg == ST_COLLECT && bit_rise
        && bitc_reg == BIT_LAST;
    assign load_stat = state_reg == ST_STATUS && !path_busy;

    // search inside the window, then collect bytes up to the line limit
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_SEARCH;
            bitc_reg <= '0;
            idx_reg <= '0;
            max_reg <= '0;
            stat_reg <= '0;
        end else begin
            case (state_reg)
                ST_SEARCH: begin
                    if (bit_rise && in_window && (ttx_hit || vps_hit)) begin
                        state_reg <= ST_COLLECT;
                        bitc_reg <= '0;
                        idx_reg <= '0;
                        max_reg <= ttx_hit ? TTX_MAX_BYTES
                            : VPS_MAX_BYTES;
                        stat_reg.is_ttx <= ttx_hit;
                        stat_reg.code_err <= ttx_hit
                            && diff_ttx != 4'h0;
                        stat_reg.code_ok <= 1'b1;
                        stat_reg.line <= line_reg;
                    end
                end
                ST_COLLECT: begin
                    if (hs_rise) begin
                        state_reg <= ST_STATUS; // line ended early
                    end else if (bit_rise) begin
                        bitc_reg <= bitc_reg + 3'h1;
                        if (load_byte) begin
                            idx_reg <= idx_reg + 6'h01;
                            if (idx_reg + 6'h01 == max_reg) begin
                                state_reg <= ST_STATUS;
                            end
                        end
                    end
                end
                ST_STATUS: begin
                    // a line cut short by hsync has already moved on, so
                    // the new line is searched rather than skipped
                    if (load_stat) begin
                        state_reg <= (line_reg != stat_reg.line) ? ST_SEARCH
                            : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // one framed line per video line
                    if (hs_rise) begin
                        state_reg <= ST_SEARCH;
                    end
                end
                default: state_reg <= ST_SEARCH;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // acquisition write path
    // ------------------------------------------------------------------
    buf_write_t acq_wr_reg;
    logic acq_load_reg;
    logic acq_req_reg;
    logic acq_go;

    assign path_busy = acq_load_reg || acq_req_reg;

    // address and data are loaded one cycle ahead of the request
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            acq_wr_reg <= '0;
        end else if (load_byte) begin
            acq_wr_reg.addr <= {line_reg, idx_reg};
            acq_wr_reg.data <= shift_next;
        end else if (load_stat) begin
            acq_wr_reg.addr <= {stat_reg.line, idx_reg};
            acq_wr_reg.data <= stat_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            acq_load_reg <= 1'b0;
            acq_req_reg <= 1'b0;
        end else begin
            acq_load_reg <= load_byte || load_stat;
            if (acq_load_reg) begin
                acq_req_reg <= 1'b1;
            end else if (acq_go) begin
                acq_req_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // buffer arbiter and line buffer
    // ------------------------------------------------------------------
    logic [7:0] mem [0:(1<<BUF_AW)-1];
    logic last_uc_reg;
    logic uc_ack_reg;
    logic [7:0] uc_rdata_reg;
    logic uc_want;
    logic uc_go;

    // round robin on a tie; the loser keeps its request and wins next
    assign uc_want = uc_req_i && !uc_ack_reg;
    assign acq_go = acq_req_reg && (!uc_want || last_uc_reg);
    assign uc_go = uc_want && !acq_go;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            last_uc_reg <= 1'b0;
        end else if (acq_go || uc_go) begin
            last_uc_reg <= uc_go;
        end
    end

    // at most one party reaches the array in any cycle
    always_ff @(posedge clk_i) begin
        if (acq_go) begin
            mem[acq_wr_reg.addr] <= acq_wr_reg.data;
        end else if (uc_go && uc_we_i) begin
            mem[uc_addr_i] <= uc_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            uc_ack_reg <= 1'b0;
            uc_rdata_reg <= BYTE_ZERO;
        end else begin
            uc_ack_reg <= uc_go;
            if (uc_go && !uc_we_i) begin
                uc_rdata_reg <= mem[uc_addr_i];
            end
        end
    end

    assign uc_ack_o = uc_ack_reg;
    assign uc_rdata_o = uc_rdata_reg;

endmodule
`default_nettype wire

// [vbi_line_acquisition_bench.sv]
// testbench: registers, framed lines, shared buffer and line 24 flag
`timescale 1ns/10ps
`default_nettype none
module vbi_line_acquisition_bench;
    import vbi_acq_pkg::*;
    localparam logic [7:0] ttx_code = 8'h27;
    localparam logic [7:0] vps_code = 8'h99;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic slice_bit_i, slice_strobe_i, hsync_i, vsync_i;
    logic [7:0] sfr_addr_i, sfr_wdata_i, uc_wdata_i;
    logic sfr_wr_i, sfr_rd_i, uc_req_i, uc_we_i;
    logic [BUF_AW-1:0] uc_addr_i;
    logic [7:0] sfr_rdata_o, uc_rdata_o, slicer_test_o;
    logic uc_ack_o, line24_done_flag_o;
    logic [1:0] run_in_compare_select_o;
    logic [31:0] seed = 32'h08741c03;
    logic [7:0] exp_data [42];
    int failures = 0;
    int samples_checked = 0;

    always #5 clk_i = ~clk_i;

    vbi_line_acquisition #(.TTX_CODE(ttx_code), .VPS_CODE(vps_code))
    i_vbi_line_acquisition (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .slice_bit_i(slice_bit_i), .slice_strobe_i(slice_strobe_i),
        .hsync_i(hsync_i), .vsync_i(vsync_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .uc_req_i(uc_req_i), .uc_we_i(uc_we_i), .uc_addr_i(uc_addr_i),
        .uc_wdata_i(uc_wdata_i), .uc_ack_o(uc_ack_o),
        .uc_rdata_o(uc_rdata_o), .line24_done_flag_o(line24_done_flag_o),
        .slicer_test_o(slicer_test_o),
        .run_in_compare_select_o(run_in_compare_select_o));

    vbi_slicer_model i_vbi_slicer_model (.clk_i(clk_i), .bit_o(slice_bit_i),
        .strobe_o(slice_strobe_i), .hsync_o(hsync_i), .vsync_o(vsync_i));

    // ------------------------------------------------------------
    // helpers; every task starts and ends on a falling edge
    // ------------------------------------------------------------
    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    function automatic logic [7:0] stat(input logic t, input logic e,
                                        input logic [4:0] ln);
        return {t, e, 1'b1, ln};
    endfunction

    task automatic check8(input string what, input logic [7:0] e,
                          input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge clk_i);
        sfr_wr_i = 1'b0;
    endtask

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge clk_i);
        sfr_rd_i = 1'b0;
        d = sfr_rdata_o;
    endtask

    // request held until ack, dropped in the ack cycle, one idle cycle
    task automatic uc_access(input logic we, input logic [BUF_AW-1:0] a,
                             input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        uc_we_i = we;
        uc_addr_i = a;
        uc_wdata_i = d;
        uc_req_i = 1'b1;
        do begin
            @(negedge clk_i);
            n++;
        end while (uc_ack_o !== 1'b1 && n < 20);
        uc_req_i = 1'b0;
        q = uc_rdata_o;
        check8("ack seen", 8'h01, {7'h00, uc_ack_o});
        @(negedge clk_i);
    endtask

    // marker at index 0, then the line while the cpu keeps reading
    task automatic frame_line(input logic [7:0] code, input int nb,
                              input logic [4:0] ln);
        logic [7:0] q;
        uc_access(1'b1, {ln, 6'h00}, 8'h5a, q);
        fork
            begin
                i_vbi_slicer_model.send_byte(8'hff);
                i_vbi_slicer_model.send_byte(code);
                for (int i = 0; i < nb; i++) begin
                    // bits 0 and 4 set, 1 and 5 clear except in the last byte, which is zero: the teletext code
                    // cannot reappear in the data inside the search window
                    exp_data[i] = (i == nb - 1) ? 8'h00
                        : (rnd8() | 8'h11) & 8'hdd;
                    i_vbi_slicer_model.send_byte(exp_data[i]);
                end
                repeat (20) @(negedge clk_i);
            end
            repeat (nb) begin
                repeat (rnd8() % 8'd40) @(negedge clk_i);
                uc_access(1'b0, {5'h05, 6'h00}, 8'h00, q);
                check8("shared read", 8'h5a, q);
            end
        join
    endtask

    // the cpu side reads each stored line back once per field
    task automatic verify(input logic [4:0] ln, input int nb,
                          input logic [7:0] st);
        logic [7:0] q;
        if (st === 8'h00) begin
            uc_access(1'b0, {ln, 6'h00}, 8'h00, q);
            check8("unstored line", 8'h5a, q);
        end else begin
            for (int i = 0; i < nb; i++) begin
                uc_access(1'b0, {ln, 6'(i)}, 8'h00, q);
                check8("line byte", exp_data[i], q);
            end
            uc_access(1'b0, {ln, 6'(nb)}, 8'h00, q);
            check8("status word", st, q);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] q;
        logic [7:0] mode;
        int k;
        // buses idle from time zero while reset holds the design
        {sfr_wr_i, sfr_rd_i, uc_req_i, uc_we_i} = 4'h0;
        {sfr_addr_i, sfr_wdata_i, uc_wdata_i} = 24'h000000;
        uc_addr_i = '0;
        repeat (6) @(negedge clk_i);
        rst_b_i = 1'b1;
        sfr_read(ADDR_MODE, q);
        check8("mode reset", MODE_RESET, q);
        sfr_read(ADDR_TEST, q);
        check8("test reset", TEST_RESET, q);
        mode = rnd8();
        sfr_write(ADDR_TEST, mode);
        sfr_read(ADDR_TEST, q);
        check8("test reg", mode, q);
        sfr_write(ADDR_TEST, TEST_RESET);
        check8("test pins", TEST_RESET, slicer_test_o);
        sfr_read(8'hc5, q);
        check8("unmapped", BYTE_ZERO, q);
        mode = 8'h23 | (rnd8() & 8'h0c); // undefined bits left zero
        sfr_write(ADDR_MODE, mode);
        sfr_read(ADDR_MODE, q);
        check8("mode reg", mode, q);
        check8("cri", {6'h00, mode[3:2]}, {6'h00, run_in_compare_select_o});
        $display("test registers done");
        i_vbi_slicer_model.pulse(1'b1);
        repeat (5) i_vbi_slicer_model.pulse(1'b0);
        frame_line(ttx_code, 42, 5'h05);
        verify(5'h05, 42, 8'h00);
        i_vbi_slicer_model.pulse(1'b0);
        frame_line(ttx_code, 42, 5'h06);
        verify(5'h06, 42, stat(1'b1, 1'b0, 5'h06));
        // low code bits excluded: they would match early inside the preamble
        k = 2 + int'(rnd8() % 8'd6);
        i_vbi_slicer_model.pulse(1'b0);
        frame_line(ttx_code ^ (8'h01 << k), 10, 5'h07);
        i_vbi_slicer_model.pulse(1'b0);
        verify(5'h07, 10, stat(1'b1, 1'b1, 5'h07));
        sfr_write(ADDR_MODE, mode & 8'hfd);
        frame_line(ttx_code ^ (8'h01 << k), 10, 5'h08);
        verify(5'h08, 10, 8'h00);
        sfr_write(ADDR_MODE, mode);
        repeat (8) i_vbi_slicer_model.pulse(1'b0);
        frame_line(vps_code, 26, 5'h10);
        verify(5'h10, 26, stat(1'b0, 1'b0, 5'h10));
        i_vbi_slicer_model.pulse(1'b0);
        frame_line(ttx_code, 42, 5'h11);
        verify(5'h11, 42, stat(1'b1, 1'b0, 5'h11));
        $display("test lines done");
        repeat (6) i_vbi_slicer_model.pulse(1'b0);
        check8("flag at 23", 8'h00, {7'h00, line24_done_flag_o});
        i_vbi_slicer_model.pulse(1'b0);
        check8("flag at 24", 8'h01, {7'h00, line24_done_flag_o});
        sfr_read(ADDR_IRQ_STATUS, q);
        check8("irq reg", 8'h10, q);
        sfr_write(ADDR_IRQ_STATUS, 8'h00);
        check8("flag clear", 8'h00, {7'h00, line24_done_flag_o});
        $display("test line 24 done");
        stop_test();
    end

    // a hang costs far more than the roughly 12500 cycles of the run
    initial begin
        #400000;
        failures++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
`default_nettype wire

// [vbi_line_acquisition_monitor.sv]
// checker: port-level assertions for the line acquisition
`timescale 1ns/10ps
`default_nettype none
module vbi_line_acquisition_monitor
    import vbi_acq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic hsync_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic uc_req_i,
    input wire logic uc_ack_o,
    input wire logic line24_done_flag_o,
    input wire logic [7:0] slicer_test_o,
    input wire logic [1:0] run_in_compare_select_o
);
    // ------------------------------------------------------------
    // assertions, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_ack_single_pulse: assert property (uc_ack_o |=> !uc_ack_o)
        else $error("buffer ack longer than one cycle");
    a_ack_has_req: assert property (uc_ack_o |-> $past(uc_req_i))
        else $error("buffer ack without request");
    // a waiting request must never be lost behind acquisition writes
    a_req_served: assert property ($rose(uc_req_i) |-> ##[1:12] uc_ack_o)
        else $error("buffer request not served");
    a_test_write: assert property (sfr_wr_i && sfr_addr_i == ADDR_TEST
        |=> slicer_test_o == $past(sfr_wdata_i))
        else $error("test register not written");
    a_mode_cri_write: assert property (sfr_wr_i && sfr_addr_i == ADDR_MODE
        |=> run_in_compare_select_o == $past(sfr_wdata_i[3:2]))
        else $error("run-in select not written");
    // hsync passes two sync flops, so the flag follows some cycles late
    a_flag_cause: assert property ($rose(line24_done_flag_o) |->
        $past(hsync_i, 2) || $past(hsync_i, 3) || $past(hsync_i, 4))
        else $error("line 24 flag set without hsync");
    a_flag_kept: assert property ($fell(line24_done_flag_o) |->
        !$past(rst_b_i) || ($past(sfr_wr_i) && $past(sfr_addr_i) == ADDR_IRQ_STATUS))
        else $error("line 24 flag lost without clear");
    a_rd_unmapped_zero: assert property (sfr_rd_i && sfr_addr_i > ADDR_TEST
        |=> sfr_rdata_o == BYTE_ZERO)
        else $error("unmapped register reads non-zero");

    c_flag_set: cover property ($rose(line24_done_flag_o));
    c_req_waits: cover property (uc_req_i && !uc_ack_o ##1 uc_req_i && !uc_ack_o);
    c_test_write: cover property (sfr_wr_i && sfr_addr_i == ADDR_TEST);
endmodule

bind vbi_line_acquisition vbi_line_acquisition_monitor i_mon (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .hsync_i(hsync_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .uc_req_i(uc_req_i),
    .uc_ack_o(uc_ack_o),
    .line24_done_flag_o(line24_done_flag_o),
    .slicer_test_o(slicer_test_o),
    .run_in_compare_select_o(run_in_compare_select_o)
);
`default_nettype wire

// [vbi_slicer_model.sv]
// partner model: data slicer pins feeding the line acquisition
`timescale 1ns/10ps
`default_nettype none
module vbi_slicer_model (
    input wire logic clk_i,
    output logic bit_o,
    output logic strobe_o,
    output logic hsync_o,
    output logic vsync_o
);
    // ------------------------------------------------------------
    // pin drivers, changed on falling edges only
    // ------------------------------------------------------------
    initial begin
        bit_o = 1'b0;
        strobe_o = 1'b0;
        hsync_o = 1'b0;
        vsync_o = 1'b0;
    end

    // data held three cycles before and five after the strobe rise
    task automatic send_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            bit_o = v[i]; // lsb first
            repeat (3) @(negedge clk_i);
            strobe_o = 1'b1;
            repeat (3) @(negedge clk_i);
            strobe_o = 1'b0;
            repeat (2) @(negedge clk_i);
        end
    endtask

    // sync pulse; data pin released, so it shows the inverse level
    task automatic pulse(input logic vert);
        hsync_o = ~vert;
        vsync_o = vert;
        bit_o = ~bit_o;
        repeat (4) @(negedge clk_i);
        hsync_o = 1'b0;
        vsync_o = 1'b0;
        repeat (8) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire
